/* common/power_mode_consts.vh */
`ifndef POWER_MODE_CONSTS_VH
`define POWER_MODE_CONSTS_VH
// register offsets
`define OFS_SYS_CLOCK_CTRL    4'h0
`define OFS_STANDBY_CTRL      4'h1
`define OFS_SYSTEM_CTRL       4'h2
`define OFS_MODE_STATUS       4'h3
// standby control layout
`define HW_STANDBY_PIN_N_SELECT_BIT       7
`define STS_HI                6
`define STS_LO                4
`define HW_STANDBY_PIN_N_RSV3_BIT         3
// system clock control layout
`define DIV_HI                2
`define DIV_LO                0
// system control layout
`define RAM_ENABLE_BIT        0
// reset values
`define RST_SYS_CLOCK_CTRL    8'h00
`define RST_STANDBY_CTRL      8'h08
`define RST_SYSTEM_CTRL       8'h01
// divide encodings
`define DIV_NONE              3'h0
`define DIV_MAX               3'h5
// settle encodings
`define STS_16_STATES         3'h7
`define STS_RESERVED          3'h6
`define SETTLE_BASE_LOG2      13
`define SETTLE_SHORT          19'h00010
// counter widths
`define SETTLE_W              19
`define PRESCALE_W            5
// hardware standby oscillator restart time
`define OSC_RESTART_NS        1000
`define CLK_PERIOD_NS         10
`endif

/* rtl/pin_sync.v */
`timescale 1ns/1ps
// three stage sync; change accepted once stages two and three agree
module pin_sync #(
   parameter RESET_VAL = 1'b1
) (
   // clock and reset
   input  wire core_clk,
   input  wire reset_n,
   // pin and clean level
   input  wire pin_in,
   output reg  level_q
);
   reg s1_q;
   reg s2_q;
   reg s3_q;

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_q    <= RESET_VAL;
         s2_q    <= RESET_VAL;
         s3_q    <= RESET_VAL;
         level_q <= RESET_VAL;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            level_q <= s3_q;
         end
      end
   end
endmodule // pin_sync

/* rtl/clock_divider.v */
`timescale 1ns/1ps
`include "power_mode_consts.vh"
// makes one enable pulse per divided state; sel 0 means every cycle
module clock_divider #(
   parameter W = `PRESCALE_W
) (
   // clock and reset
   input  wire         core_clk,
   input  wire         reset_n,
   // control
   input  wire [2:0]   div_sel,
   input  wire         run,
   // divided state tick
   output wire         tick
);
   reg  [W-1:0] cnt_q;
   wire [W-1:0] mask;

   assign mask = (div_sel == `DIV_NONE) ? {W{1'b0}} :
                 ((({{(W-1){1'b0}}, 1'b1}) << div_sel) - 1'b1);
   assign tick = run && ((cnt_q & mask) == mask);

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= {W{1'b0}};
      end else if (!run) begin
         cnt_q <= {W{1'b0}};
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end
endmodule // clock_divider

/* rtl/power_mode_controller.v */
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "power_mode_consts.vh"
module power_mode_controller #(
   parameter OSC_RESTART_CYC = (`OSC_RESTART_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
   // clock and reset
   input  wire         core_clk,
   input  wire         reset_n,
   // register port
   input  wire [3:0]   reg_addr,
   input  wire [7:0]   reg_wdata,
   input  wire         reg_wr,
   input  wire         reg_rd,
   output reg  [7:0]   reg_rdata,
   // cpu and interrupt side
   input  wire         sleep_exec,
   input  wire         bus_cycle_end,
   input  wire         nmi_req,
   input  wire         irq_req,
   input  wire         irq_enabled,
   input  wire         irq_cpu_masked,
   input  wire         irq_is_dtc_source,
   input  wire         watchdog_reset,
   // pins
   input  wire         external_reboot_n,
   input  wire         hw_standby_pin_n,
   // clock and mode outputs
   output wire         cpu_tick,
   output wire         transfer_tick,
   output wire         periph_tick,
   output wire         osc_enable,
   output reg          cpu_halt,
   output wire         periph_stop,
   output wire         chip_reset,
   output wire         ports_float,
   output wire         ram_enable,
   output reg          reset_exception,
   output reg          irq_exception
);
   localparam ST_RUN     = 5'h01;
   localparam ST_SLEEP   = 5'h02;
   localparam ST_SWSTBY  = 5'h04;
   localparam ST_SETTLE  = 5'h08;
   localparam ST_RESET   = 5'h10;

   wire rst_pin_q;
   wire hw_standby_pin_n_pin_q;
   reg  [4:0]  state_q;
   reg  [4:0]  state_d;
   reg  [7:0]  clk_ctrl_q;
   reg  [7:0]  hw_standby_pin_n_ctrl_q;
   reg  [7:0]  sys_ctrl_q;
   reg  [2:0]  div_active_q;
   reg  [`SETTLE_W-1:0] settle_q;
   reg         hw_standby_q;
   reg  [15:0] osc_cnt_q;
   wire        wake_irq;
   wire        any_wake;
   wire        hold_reset;
   wire        div_tick;

   function [`SETTLE_W-1:0] settle_count;
      input [2:0] sel;
      begin
         if (sel == `STS_16_STATES) begin
            settle_count = `SETTLE_SHORT;
         end else if (sel == `STS_RESERVED) begin
            settle_count = {`SETTLE_W{1'b1}};
         end else begin
            settle_count = {{(`SETTLE_W-1){1'b0}}, 1'b1} << (`SETTLE_BASE_LOG2 + sel);
         end
      end
   endfunction

   // the only state besides reset with the oscillator stopped and no settle count running
   function is_hw_standby_pin_n;
      input [4:0] st;
      begin
         is_hw_standby_pin_n = (st == ST_SWSTBY);
      end
   endfunction

   // undefined codes fall back to the slowest rate
   function [2:0] clamp_div;
      input [2:0] sel;
      begin
         if (sel > `DIV_MAX) begin
            clamp_div = `DIV_MAX;
         end else begin
            clamp_div = sel;
         end
      end
   endfunction

   pin_sync #(.RESET_VAL(1'b0)) u_rst_sync (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .pin_in   (external_reboot_n),
      .level_q  (rst_pin_q)
   );

   pin_sync #(.RESET_VAL(1'b0)) u_hw_standby_pin_n_sync (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .pin_in   (hw_standby_pin_n),
      .level_q  (hw_standby_pin_n_pin_q)
   );

   clock_divider #(.W(`PRESCALE_W)) u_div (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .div_sel  (div_active_q),
      .run      (!hold_reset),
      .tick     (div_tick)
   );

   // nmi bypasses cpu mask; dtc sourced irq never wakes
   assign wake_irq = irq_req && irq_enabled && !irq_cpu_masked && !irq_is_dtc_source;
   assign any_wake = nmi_req || wake_irq;
   assign hold_reset    = !rst_pin_q || watchdog_reset || hw_standby_q;
   assign cpu_tick      = div_tick && !cpu_halt;
   assign transfer_tick = div_tick && !periph_stop;
   assign periph_tick   = !periph_stop && !hold_reset;
   assign periph_stop   = is_hw_standby_pin_n(state_q) || (state_q == ST_SETTLE);
   // crude oscillator model: off in standby, restart delay after hw standby
   assign osc_enable    = !is_hw_standby_pin_n(state_q) && !hw_standby_q &&
                          (osc_cnt_q == 16'h0000);
   assign chip_reset    = hold_reset;
   assign ports_float   = hw_standby_q;
   assign ram_enable    = sys_ctrl_q[`RAM_ENABLE_BIT];

   // hardware standby and oscillator restart
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         hw_standby_q <= 1'b1;
         osc_cnt_q    <= 16'h0000;
      end else begin
         if (!hw_standby_pin_n_pin_q) begin
            hw_standby_q <= 1'b1;
            // reloaded while the pin stays low, so the delay counts from its rise
            osc_cnt_q    <= OSC_RESTART_CYC[15:0];
         end else if (hw_standby_q && !rst_pin_q) begin
            hw_standby_q <= 1'b0;
         end else if (osc_cnt_q != 16'h0000) begin
            osc_cnt_q <= osc_cnt_q - 16'h0001;
         end
      end
   end

   // registers; all three control registers return to reset values under hold_reset
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         clk_ctrl_q  <= `RST_SYS_CLOCK_CTRL;
         hw_standby_pin_n_ctrl_q <= `RST_STANDBY_CTRL;
         sys_ctrl_q  <= `RST_SYSTEM_CTRL;
      end else if (hold_reset) begin
         clk_ctrl_q  <= `RST_SYS_CLOCK_CTRL;
         hw_standby_pin_n_ctrl_q <= `RST_STANDBY_CTRL;
         sys_ctrl_q  <= `RST_SYSTEM_CTRL;
      end else if (reg_wr) begin
         case (reg_addr)
            `OFS_SYS_CLOCK_CTRL: begin
               clk_ctrl_q <= {5'h00, reg_wdata[`DIV_HI:`DIV_LO]};
            end
            `OFS_STANDBY_CTRL: begin
               hw_standby_pin_n_ctrl_q <= {reg_wdata[`HW_STANDBY_PIN_N_SELECT_BIT], reg_wdata[`STS_HI:`STS_LO],
                               1'b1, 3'h0};
            end
            `OFS_SYSTEM_CTRL: begin
               sys_ctrl_q <= {7'h00, reg_wdata[`RAM_ENABLE_BIT]};
            end
            default: begin
            end
         endcase
      end
   end

   // division changes only at bus cycle end in run, and clears under hold_reset; kept across sleep and software standby
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         div_active_q <= `DIV_NONE;
      end else if (hold_reset) begin
         div_active_q <= `DIV_NONE;
      end else if (bus_cycle_end && (state_q == ST_RUN)) begin
         div_active_q <= clamp_div(clk_ctrl_q[`DIV_HI:`DIV_LO]);
      end
   end

   // read port
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `OFS_SYS_CLOCK_CTRL: reg_rdata <= clk_ctrl_q;
            `OFS_STANDBY_CTRL:   reg_rdata <= hw_standby_pin_n_ctrl_q;
            `OFS_SYSTEM_CTRL:    reg_rdata <= sys_ctrl_q;
            `OFS_MODE_STATUS:    reg_rdata <= {state_q, div_active_q};
            default:             reg_rdata <= 8'h00;
         endcase
      end else begin
         // read data stands for one cycle only
         reg_rdata <= 8'h00;
      end
   end

   always @* begin
      state_d = state_q;
      case (state_q)
         ST_RUN: begin
            if (sleep_exec && hw_standby_pin_n_ctrl_q[`HW_STANDBY_PIN_N_SELECT_BIT]) begin
               state_d = ST_SWSTBY;
            end else if (sleep_exec) begin
               state_d = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (any_wake) begin
               state_d = ST_RUN;
            end
         end
         ST_SWSTBY: begin
            if (any_wake) begin
               state_d = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            if (settle_q == {`SETTLE_W{1'b0}}) begin
               state_d = ST_RUN;
            end
         end
         ST_RESET: begin
            state_d = ST_RUN;
         end
         default: begin
            state_d = ST_RESET;
         end
      endcase
      // any reset source overrides every mode
      if (hold_reset) begin
         state_d = ST_RESET;
      end
   end

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= ST_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   // one cycle pulses; halt follows the next state so it drops with the wake
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cpu_halt        <= 1'b1;
         reset_exception <= 1'b0;
         irq_exception   <= 1'b0;
      end else begin
         reset_exception <= (state_q == ST_RESET) && (state_d == ST_RUN);
         irq_exception   <= (state_d == ST_RUN) &&
                            ((state_q == ST_SLEEP) || (state_q == ST_SETTLE));
         cpu_halt        <= (state_d != ST_RUN);
      end
   end

   // reloaded on every standby cycle, so the field as written last decides the wait
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         settle_q <= {`SETTLE_W{1'b0}};
      end else if (is_hw_standby_pin_n(state_q)) begin
         settle_q <= settle_count(hw_standby_pin_n_ctrl_q[`STS_HI:`STS_LO]) - 1'b1;
      end else if (settle_q != {`SETTLE_W{1'b0}}) begin
         settle_q <= settle_q - 1'b1;
      end
   end
endmodule // power_mode_controller

/* test/power_mode_chk.sv */
`timescale 1ns/1ps
module power_mode_chk (
   // clock and reset
   input logic core_clk,
   input logic reset_n,
   // wake and reset causes
   input logic sleep_exec,
   input logic nmi_req,
   input logic irq_req,
   input logic irq_enabled,
   input logic irq_cpu_masked,
   input logic watchdog_reset,
   // mode outputs
   input logic cpu_tick,
   input logic transfer_tick,
   input logic periph_tick,
   input logic osc_enable,
   input logic cpu_halt,
   input logic periph_stop,
   input logic chip_reset,
   input logic ports_float,
   input logic reset_exception,
   input logic irq_exception
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   property p_float; ports_float |-> chip_reset; endproperty
   a_float: assert property (p_float) else $error("ports float out of reset");
   property p_sleep;
      sleep_exec && !cpu_halt && !periph_stop && !chip_reset && !nmi_req |=> cpu_halt;
   endproperty
   a_sleep: assert property (p_sleep) else $error("cpu kept running");
   property p_halt_tick; cpu_halt |-> !cpu_tick; endproperty
   a_halt_tick: assert property (p_halt_tick) else $error("tick while halted");
   property p_periph; !periph_stop && !chip_reset |-> periph_tick; endproperty
   a_periph: assert property (p_periph) else $error("peripherals stopped");
   property p_stop; periph_stop |-> !cpu_tick && !transfer_tick; endproperty
   a_stop: assert property (p_stop) else $error("ticks in standby");
   property p_exc; irq_exception |-> $past(cpu_halt); endproperty
   a_exc: assert property (p_exc) else $error("wake without halt");
   property p_mask;
      cpu_halt && !periph_stop && !chip_reset && !nmi_req
         && !(irq_req && irq_enabled && !irq_cpu_masked) |=> !irq_exception;
   endproperty
   a_mask: assert property (p_mask) else $error("masked wake");
   property p_rexc; $fell(chip_reset) |-> ##[1:3] reset_exception; endproperty
   a_rexc: assert property (p_rexc) else $error("no reset exception");
   property p_wdog; watchdog_reset ##1 watchdog_reset |-> chip_reset; endproperty
   a_wdog: assert property (p_wdog) else $error("watchdog ignored");
   property p_settle; $fell(periph_stop) && !chip_reset |-> $past(osc_enable); endproperty
   a_settle: assert property (p_settle) else $error("left without oscillator");
endmodule // power_mode_chk
bind power_mode_controller power_mode_chk i_chk (.core_clk, .reset_n, .sleep_exec, .nmi_req,
   .irq_req, .irq_enabled, .irq_cpu_masked, .watchdog_reset, .cpu_tick, .transfer_tick,
   .periph_tick, .osc_enable, .cpu_halt, .periph_stop, .chip_reset, .ports_float,
   .reset_exception, .irq_exception);

/* test/pin_model.sv */
`timescale 1ns/1ps
module pin_model (
   // clock
   input  logic core_clk,
   // pins
   output logic external_reboot_n,
   output logic hw_standby_pin_n
);
   initial begin
      external_reboot_n = 1'b0;
      hw_standby_pin_n = 1'b1;
   end
   // reset goes low first so ram survives the fall
   task automatic enter_hw_standby();
      @(posedge core_clk) external_reboot_n <= 1'b0;
      repeat (10) @(posedge core_clk);
      hw_standby_pin_n <= 1'b0;
   endtask
   // boot config pins are never touched here
   task automatic leave_hw_standby(input int osc_cyc);
      @(posedge core_clk) external_reboot_n <= 1'b0;
      repeat (10) @(posedge core_clk);
      hw_standby_pin_n <= 1'b1;
      repeat (osc_cyc + 12) @(posedge core_clk);
      external_reboot_n <= 1'b1;
   endtask
endmodule // pin_model

/* test/tb.sv */
`timescale 1ns/1ps
`include "power_mode_consts.vh"
module tb;
   localparam int OSC = 2;
   logic core_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic sleep_exec = 1'b0, bus_cycle_end = 1'b0, nmi_req = 1'b0, irq_req = 1'b0;
   logic irq_enabled = 1'b0, irq_cpu_masked = 1'b0, irq_is_dtc_source = 1'b0;
   logic watchdog_reset = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   wire [7:0] reg_rdata;
   wire cpu_tick, transfer_tick, periph_tick, osc_enable, cpu_halt, periph_stop;
   wire chip_reset, ports_float, ram_enable, reset_exception, irq_exception;
   wire external_reboot_n, hw_standby_pin_n;
   int fails = 0;
   int checks = 0;
   always #5 core_clk = ~core_clk;
   power_mode_controller #(.OSC_RESTART_CYC(OSC)) i_dut (.core_clk, .reset_n, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sleep_exec, .bus_cycle_end, .nmi_req,
      .irq_req, .irq_enabled, .irq_cpu_masked, .irq_is_dtc_source, .watchdog_reset,
      .external_reboot_n, .hw_standby_pin_n, .cpu_tick, .transfer_tick, .periph_tick,
      .osc_enable, .cpu_halt, .periph_stop, .chip_reset, .ports_float, .ram_enable,
      .reset_exception, .irq_exception);
   pin_model i_pins (.core_clk, .external_reboot_n, .hw_standby_pin_n);
   task automatic complete_run();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   task automatic bus_end();
      @(posedge core_clk) bus_cycle_end <= 1'b1;
      @(posedge core_clk) bus_cycle_end <= 1'b0;
   endtask
   task automatic sleep_cmd();
      @(posedge core_clk) sleep_exec <= 1'b1;
      @(posedge core_clk) sleep_exec <= 1'b0;
   endtask
   // order: nmi, irq, enabled, cpu masked, transfer source
   task automatic set_wake(input logic [4:0] v);
      @(posedge core_clk);
      {nmi_req, irq_req, irq_enabled, irq_cpu_masked, irq_is_dtc_source} <= v;
   endtask
   task automatic wait_irq(input int lim, output int n);
      for (n = 0; n < lim && irq_exception !== 1'b1; n++) step(1);
   endtask
   // pin reset walk; also the only way out of the power-up hold
   task automatic reboot();
      int n;
      fork
         i_pins.leave_hw_standby(OSC);
         begin
            step(20);
            chk(chip_reset, 1'b1);
            chk(osc_enable, 1'b1);
         end
      join
      for (n = 0; n < 40 && reset_exception !== 1'b1; n++) step(1);
      chk(n < 40, 1'b1);
   endtask
   task automatic t_regs();
      rdc(`OFS_SYS_CLOCK_CTRL, `RST_SYS_CLOCK_CTRL);
      rdc(`OFS_STANDBY_CTRL, `RST_STANDBY_CTRL);
      rdc(`OFS_SYSTEM_CTRL, `RST_SYSTEM_CTRL);
      rdc(`OFS_MODE_STATUS, 8'h08);
      rdc(4'hF, 8'h00);
      wr(`OFS_STANDBY_CTRL, 8'h57);
      rdc(`OFS_STANDBY_CTRL, 8'h58);
      wr(`OFS_STANDBY_CTRL, 8'h08);
      $display("regs done");
   endtask
   task automatic t_divide();
      int i, c, t, p;
      logic [2:0] eff, prev;
      prev = 3'h0;
      for (i = 0; i < 9; i++) begin
         if (i == 6) continue;
         eff = (i == 8) ? 3'h0 : ((i > 5) ? 3'h5 : i[2:0]);
         wr(`OFS_SYS_CLOCK_CTRL, {5'h00, (i == 8) ? 3'h0 : i[2:0]});
         rdc(`OFS_MODE_STATUS, {5'h01, prev});
         bus_end();
         rdc(`OFS_MODE_STATUS, {5'h01, eff});
         c = 0;
         t = 0;
         p = 0;
         repeat (64) begin
            step(1);
            c += (cpu_tick === 1'b1);
            t += (transfer_tick === 1'b1);
            p += (periph_tick === 1'b1);
         end
         chk(c, 64 >> eff);
         chk(t, 64 >> eff);
         chk(p, 64);
         prev = eff;
      end
      $display("divide done");
   endtask
   task automatic t_sleep();
      int n;
      wr(`OFS_SYS_CLOCK_CTRL, 8'h02);
      bus_end();
      sleep_cmd();
      set_wake(5'b01110);
      step(6);
      chk(cpu_halt, 1'b1);
      chk(periph_tick, 1'b1);
      set_wake(5'b01000);
      step(6);
      chk(cpu_halt, 1'b1);
      set_wake(5'b01100);
      wait_irq(8, n);
      chk(n < 8, 1'b1);
      set_wake(5'b00000);
      rdc(`OFS_MODE_STATUS, 8'h0A);
      sleep_cmd();
      set_wake(5'b10010);
      wait_irq(8, n);
      chk(n < 8, 1'b1);
      set_wake(5'b00000);
      $display("sleep done");
   endtask
   task automatic t_soft(input logic [2:0] sts, input int nst, input logic use_nmi);
      int n;
      wr(`OFS_STANDBY_CTRL, {1'b1, sts, 4'h0});
      rdc(`OFS_STANDBY_CTRL, {1'b1, sts, 4'h8});
      sleep_cmd();
      rdc(`OFS_MODE_STATUS, 8'h22);
      chk(osc_enable, 1'b0);
      chk(periph_stop, 1'b1);
      chk({periph_tick, cpu_tick, transfer_tick}, 3'b000);
      set_wake(5'b01101);
      step(6);
      chk(periph_stop, 1'b1);
      set_wake(5'b01110);
      step(6);
      chk(periph_stop, 1'b1);
      set_wake(use_nmi ? 5'b11110 : 5'b01100);
      wait_irq(nst + 10, n);
      chk(n >= nst && n <= nst + 4, 1'b1);
      set_wake(5'b00000);
      rdc(`OFS_MODE_STATUS, 8'h0A);
      $display("standby done");
   endtask
   task automatic t_resets();
      int n;
      sleep_cmd();
      step(2);
      chk(osc_enable, 1'b0);
      reboot();
      wr(`OFS_SYS_CLOCK_CTRL, 8'h03);
      bus_end();
      @(posedge core_clk) watchdog_reset <= 1'b1;
      step(3);
      chk(chip_reset, 1'b1);
      @(posedge core_clk) watchdog_reset <= 1'b0;
      for (n = 0; n < 20 && chip_reset !== 1'b0; n++) step(1);
      rdc(`OFS_MODE_STATUS, 8'h08);
      wr(`OFS_SYSTEM_CTRL, 8'h00);
      step(1);
      chk(ram_enable, 1'b0);
      i_pins.enter_hw_standby();
      step(6);
      chk({ports_float, chip_reset, osc_enable}, 3'b110);
      reboot();
      chk(ports_float, 1'b0);
      rdc(`OFS_SYSTEM_CTRL, 8'h01);
      $display("resets done");
   endtask
   initial begin
      #500000;
      fails++;
      complete_run();
   end
   initial begin
      repeat (6) @(posedge core_clk);
      reset_n <= 1'b1;
      reboot();
      t_regs();
      t_divide();
      t_sleep();
      // legal codes only; expected waits equal the settle counts of codes 1 and 0 (16384 and 8192 states)
      t_soft(3'h1, 16384, 1'b1);
      t_soft(3'h0, 8192, 1'b0);
      t_resets();
      complete_run();
   end
endmodule // tb
